// File: logic/sacs_defs.svh
`ifndef SACS_DEFS_SVH
`define SACS_DEFS_SVH

// Register addresses on the plain register port
`define SACS_ADDR_CONTROL 4'h0
`define SACS_ADDR_CONFIG 4'h1
`define SACS_ADDR_DATA 4'h2
`define SACS_ADDR_CHANNEL 4'h3
`define SACS_ADDR_SHARED 4'h4

// Control register fields
`define SACS_CTL_ENABLE 7
`define SACS_CTL_TRACK 6
`define SACS_CTL_DONE 5
`define SACS_CTL_BUSY 4
`define SACS_CTL_SRC_HI 3
`define SACS_CTL_SRC_LO 1
`define SACS_CTL_RESET 8'h00

// Configuration register fields
`define SACS_CFG_DIV_HI 7
`define SACS_CFG_DIV_LO 3
`define SACS_CFG_GAIN_HI 1
`define SACS_CFG_GAIN_LO 0
`define SACS_CFG_RESET 8'hF8
`define SACS_CFG_MASK 8'hFB

// Channel register keeps three bits
`define SACS_CHAN_MASK 8'h07

// Shared start register: writing this bit mimics the primary busy write
`define SACS_SHARED_BUSY 4

// Sequencing counts in conversion clocks
`define SACS_TRACK_CLOCKS 4'h3
`define SACS_CONV_CLOCKS 4'h8

// Timing figures
`define SACS_SYS_CLOCK_HZ 50000000
`define SACS_SAR_MAX_HZ 7500000
`define SACS_DIV_MIN ((`SACS_SYS_CLOCK_HZ + `SACS_SAR_MAX_HZ - 1) / `SACS_SAR_MAX_HZ - 1)

`endif

// File: logic/sacs_pkg.sv
package sacs_pkg;

    // Start-of-conversion source codes
    typedef enum logic [2:0] {
        SACS_SRC_SOFT = 3'h0,
        SACS_SRC_TIMER3 = 3'h1,
        SACS_SRC_EXTERNAL = 3'h2,
        SACS_SRC_TIMER2 = 3'h3,
        SACS_SRC_SHARED = 3'h4
    } sacs_src_e;

    // Amplifier gain codes
    typedef enum logic [1:0] {
        SACS_GAIN_HALF = 2'h0,
        SACS_GAIN_ONE = 2'h1,
        SACS_GAIN_TWO = 2'h2,
        SACS_GAIN_FOUR = 2'h3
    } sacs_gain_e;

    // Sequencer states
    typedef enum logic [1:0] {
        SACS_IDLE,
        SACS_TRACK,
        SACS_CONVERT
    } sacs_state_e;

endpackage

// File: logic/sacs_clock_divider.sv
`timescale 1ns/100ps
`include "sacs_defs.svh"

// Produces a one-cycle enable every (divisor + 1) system clocks
module sacs_clock_divider #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Control
    input wire logic i_run,
    input wire logic [WIDTH-1:0] i_divisor,
    // Enable pulse
    output logic o_tick
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic tick_reg;
    wire at_end = (count_reg >= i_divisor);

    // Restart count whenever stopped so each run begins with a full period
    assign count_next = (!i_run || at_end) ? '0 : count_reg + 1'b1;

    // Counter and pulse registers
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= i_run && at_end;
        end
    end

    assign o_tick = tick_reg;

    // Pulse spacing equals divisor plus one; a zero divisor ticks every cycle
    a_tick_spacing: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (o_tick && i_run && (i_divisor != '0) && $stable(i_divisor)) |=> !o_tick)
        else $error("tick repeated on consecutive cycles");
endmodule // sacs_clock_divider

// File: logic/sacs_sequencer.sv
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "sacs_defs.svh"

module sacs_sequencer
    import sacs_pkg::*;
#(
    parameter int DIV_WIDTH = 5,
    parameter int DATA_WIDTH = 8
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Start triggers and chip standby
    input wire logic i_timer3_overflow,
    input wire logic i_timer2_overflow,
    input wire logic i_external_convert_start,
    input wire logic i_primary_busy_write,
    input wire logic i_chip_standby,
    // Analog front end
    input wire logic [DATA_WIDTH-1:0] i_sar_result,
    output logic o_converter_enable,
    output logic o_track,
    output logic o_convert,
    output logic o_sar_tick,
    output sacs_pkg::sacs_gain_e o_gain_select,
    output logic [2:0] o_channel_select,
    // Completion
    output logic o_conversion_done,
    output logic o_interrupt_request
);
    import sacs_pkg::*;

    // Register fields
    logic [7:0] control_reg;  // Enable, track, done, busy, source
    logic [7:0] config_reg;  // Divider and gain
    logic [7:0] channel_reg;  // Input multiplexer selection
    logic [DATA_WIDTH-1:0] data_reg;  // Last result
    logic [7:0] rdata_reg;  // Read data, valid one cycle after strobe
    sacs_state_e state_reg;
    sacs_state_e state_next;
    logic [3:0] clocks_reg;  // Conversion clocks spent in a phase
    logic [3:0] clocks_next;
    logic ext_prev_reg;  // Previous sample of external start
    logic busy_prev_reg;  // Previous busy for falling edge
    logic irq_reg;
    logic track_reg;
    logic convert_reg;

    // Decoded fields
    wire enable = control_reg[`SACS_CTL_ENABLE];
    wire low_power = control_reg[`SACS_CTL_TRACK];
    wire busy = control_reg[`SACS_CTL_BUSY];
    wire [2:0] source = control_reg[`SACS_CTL_SRC_HI:`SACS_CTL_SRC_LO];
    wire [DIV_WIDTH-1:0] divisor = config_reg[`SACS_CFG_DIV_HI:`SACS_CFG_DIV_LO];
    wire sar_tick;

    // Register decode, shared by the write paths
    function automatic logic hit(input logic [3:0] a, input logic [3:0] target, input logic strobe);
        hit = strobe && (a == target);
    endfunction

    wire wr_control = hit(i_addr, `SACS_ADDR_CONTROL, i_wr);
    wire wr_config = hit(i_addr, `SACS_ADDR_CONFIG, i_wr);
    wire wr_channel = hit(i_addr, `SACS_ADDR_CHANNEL, i_wr);
    wire wr_shared = hit(i_addr, `SACS_ADDR_SHARED, i_wr);
    wire soft_busy_write = wr_control && i_wdata[`SACS_CTL_BUSY];
    // Primary busy write or its alias
    wire shared_write = i_primary_busy_write || (wr_shared && i_wdata[`SACS_SHARED_BUSY]);
    wire ext_rise = i_external_convert_start && !ext_prev_reg;

    wire start_selected = (source == SACS_SRC_SOFT) ? soft_busy_write :
                          (source == SACS_SRC_TIMER3) ? i_timer3_overflow :
                          (source == SACS_SRC_EXTERNAL) ? ext_rise :
                          (source == SACS_SRC_TIMER2) ? i_timer2_overflow :
                          (source == SACS_SRC_SHARED) ? shared_write : 1'b0;
    // Starts ignored while disabled or busy
    wire start = enable && !busy && (state_reg == SACS_IDLE) && start_selected;
    // External low-power start converts at once, having tracked while low
    wire skip_track = !low_power || (source == SACS_SRC_EXTERNAL);
    wire phase_end_track = sar_tick && (clocks_reg == `SACS_TRACK_CLOCKS - 4'h1);
    wire phase_end_conv = sar_tick && (clocks_reg == `SACS_CONV_CLOCKS - 4'h1);
    wire finish = (state_reg == SACS_CONVERT) && phase_end_conv;

    sacs_clock_divider #(
        .WIDTH(DIV_WIDTH)
    ) u_divider (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_run(state_reg != SACS_IDLE),
        .i_divisor(divisor),
        .o_tick(sar_tick)
    );

    always_comb begin
        state_next = state_reg;
        clocks_next = clocks_reg;
        unique case (state_reg)
            SACS_IDLE: begin
                clocks_next = 4'h0;
                if (start) begin
                    state_next = skip_track ? SACS_CONVERT : SACS_TRACK;
                end
            end
            SACS_TRACK: begin
                if (phase_end_track) begin
                    state_next = SACS_CONVERT;
                    clocks_next = 4'h0;
                end else if (sar_tick) begin
                    clocks_next = clocks_reg + 4'h1;
                end
            end
            SACS_CONVERT: begin
                if (phase_end_conv) begin
                    state_next = SACS_IDLE;
                    clocks_next = 4'h0;
                end else if (sar_tick) begin
                    clocks_next = clocks_reg + 4'h1;
                end
            end
        endcase
        if (!enable) begin
            state_next = SACS_IDLE;
            clocks_next = 4'h0;
        end
    end

    // Sequencer state
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_reg <= SACS_IDLE;
            clocks_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            clocks_reg <= clocks_next;
        end
    end

    // Control register: software fields, busy owned by hardware, done written by software and set by hardware
    // Busy high for whole conversion
    // Done set on busy fall, set beats clear
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            control_reg <= `SACS_CTL_RESET;
        end else begin
            if (wr_control) begin
                control_reg[`SACS_CTL_ENABLE] <= i_wdata[`SACS_CTL_ENABLE];
                control_reg[`SACS_CTL_TRACK] <= i_wdata[`SACS_CTL_TRACK];
                control_reg[`SACS_CTL_DONE] <= i_wdata[`SACS_CTL_DONE];
                control_reg[`SACS_CTL_SRC_HI:`SACS_CTL_SRC_LO] <= i_wdata[`SACS_CTL_SRC_HI:`SACS_CTL_SRC_LO];
            end
            if (busy_prev_reg && !busy) begin
                control_reg[`SACS_CTL_DONE] <= 1'b1;
            end
            control_reg[`SACS_CTL_BUSY] <= enable && (state_next != SACS_IDLE);
            control_reg[0] <= 1'b0;
        end
    end

    // Configuration and channel registers
    // Gain resets to half
    // Gain code held in low bits
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            config_reg <= `SACS_CFG_RESET;
            channel_reg <= 8'h00;
        end else begin
            if (wr_config) begin
                config_reg <= i_wdata & `SACS_CFG_MASK;
            end
            if (wr_channel) begin
                channel_reg <= i_wdata & `SACS_CHAN_MASK;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            data_reg <= '0;
        end else if (finish) begin
            data_reg <= i_sar_result;
        end
    end

    // Edge history, interrupt pulse and front-end controls
    // Normal mode tracks while idle
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            // Idle-high pin must not look like an edge after reset
            ext_prev_reg <= 1'b1;
            busy_prev_reg <= 1'b0;
            irq_reg <= 1'b0;
            track_reg <= 1'b0;
            convert_reg <= 1'b0;
        end else begin
            ext_prev_reg <= i_external_convert_start;
            busy_prev_reg <= busy;
            irq_reg <= busy_prev_reg && !busy;
            convert_reg <= enable && (state_next == SACS_CONVERT);
            track_reg <= enable && !i_chip_standby && (
                (state_next == SACS_TRACK) ||
                ((state_next == SACS_IDLE) && !low_power) ||
                ((state_next == SACS_IDLE) && (source == SACS_SRC_EXTERNAL) && !i_external_convert_start));
        end
    end

    // Read data one cycle after strobe; unmapped addresses read zero
    wire [7:0] read_mux = (i_addr == `SACS_ADDR_CONTROL) ? control_reg :
                          (i_addr == `SACS_ADDR_CONFIG) ? config_reg :
                          (i_addr == `SACS_ADDR_DATA) ? data_reg :
                          (i_addr == `SACS_ADDR_CHANNEL) ? channel_reg : 8'h00;
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= i_rd ? read_mux : 8'h00;
        end
    end

    // Outputs
    assign o_rdata = rdata_reg;
    assign o_converter_enable = enable;
    assign o_track = track_reg;
    assign o_convert = convert_reg;
    assign o_sar_tick = sar_tick;
    assign o_gain_select = sacs_gain_e'(config_reg[`SACS_CFG_GAIN_HI:`SACS_CFG_GAIN_LO]);
    assign o_channel_select = channel_reg[2:0];
    assign o_conversion_done = control_reg[`SACS_CTL_DONE];
    assign o_interrupt_request = irq_reg;

    // Completion sequence
    sequence s_busy_fall;
        busy_prev_reg && !busy;
    endsequence

    a_done_on_fall: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        s_busy_fall |=> o_conversion_done && o_interrupt_request)
        else $error("done flag not set after busy fall");
    a_disabled_idle: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        !enable |=> !busy)
        else $error("busy while disabled");
    a_busy_converting: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_convert |-> busy)
        else $error("converting without busy");
    a_soft_start: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (start && source == SACS_SRC_SOFT) |=> busy)
        else $error("software start ignored");
    a_timer_start: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (enable && !busy && state_reg == SACS_IDLE && source == SACS_SRC_TIMER3 && i_timer3_overflow) |=> busy)
        else $error("timer overflow ignored");
    a_ext_start: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (start && source == SACS_SRC_EXTERNAL) |=> state_reg == SACS_CONVERT)
        else $error("external edge did not convert");
    a_shared_start: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (enable && !busy && state_reg == SACS_IDLE && source == SACS_SRC_SHARED && i_primary_busy_write) |=> busy)
        else $error("shared start ignored");
    a_track_first: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (start && !skip_track) |=> state_reg == SACS_TRACK)
        else $error("low-power start skipped tracking");
    a_result_held: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        finish |=> data_reg == $past(i_sar_result))
        else $error("result not captured");
    a_off_no_track: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (!enable || i_chip_standby) |=> !o_track)
        else $error("tracking while shut down");
    a_off_no_convert: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        !enable |=> !o_convert)
        else $error("converting while shut down");
    a_track_excludes: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_convert |-> !o_track)
        else $error("tracking during conversion");
    a_unused_source: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == SACS_IDLE && source > SACS_SRC_SHARED) |=> state_reg == SACS_IDLE)
        else $error("unused source code started a conversion");
endmodule // sacs_sequencer

// File: verification/sacs_trigger_model.sv
`timescale 1ns/100ps

// Stands in for timers 2 and 3 and the convert-start pin
module sacs_trigger_model #(
    parameter int T3_PERIOD = 37,
    parameter int T2_PERIOD = 53
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Pin level asked for by the bench
    input wire logic i_ext_level,
    // Overflows and pin
    output logic o_timer3_overflow,
    output logic o_timer2_overflow,
    output logic o_external_convert_start
);
    // Timer counts; periods differ so the two line up only once every 1961 cycles
    int t3_reg;
    int t2_reg;
    wire logic t3_wrap = t3_reg == T3_PERIOD - 1;
    wire logic t2_wrap = t2_reg == T2_PERIOD - 1;

    // Free running: overflow is one cycle, pin changes just after an edge
    always_ff @(posedge i_clock) begin
        t3_reg <= (!i_rst_b || t3_wrap) ? 0 : t3_reg + 1;
        t2_reg <= (!i_rst_b || t2_wrap) ? 0 : t2_reg + 1;
        o_timer3_overflow <= i_rst_b && t3_wrap;
        o_timer2_overflow <= i_rst_b && t2_wrap;
        o_external_convert_start <= i_ext_level;
    end
endmodule // sacs_trigger_model

// File: verification/sacs_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "sacs_defs.svh"

module sacs_sequencer_tb_top;
    import sacs_pkg::*;
    // Divider kept just inside the 7.5 MHz ceiling
    localparam logic [4:0] DIV = 5'h6;
    logic i_clock = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, i_sar_result = 8'h00, o_rdata;
    logic ext_req = 1'b1, primary_write = 1'b0, standby = 1'b0;
    logic t3_ovf, t2_ovf, ext_pin, o_enable, o_track, o_convert, o_tick, o_done, o_irq;
    logic [2:0] o_chan;
    sacs_gain_e o_gain;
    int n_errors = 0, n_tests = 0;

    sacs_trigger_model i_sacs_trigger_model (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ext_level(ext_req),
        .o_timer3_overflow(t3_ovf), .o_timer2_overflow(t2_ovf), .o_external_convert_start(ext_pin));
    sacs_sequencer i_sacs_sequencer (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer3_overflow(t3_ovf),
        .i_timer2_overflow(t2_ovf), .i_external_convert_start(ext_pin), .i_primary_busy_write(primary_write),
        .i_chip_standby(standby), .i_sar_result(i_sar_result), .o_converter_enable(o_enable),
        .o_track(o_track), .o_convert(o_convert), .o_sar_tick(o_tick), .o_gain_select(o_gain),
        .o_channel_select(o_chan), .o_conversion_done(o_done), .o_interrupt_request(o_irq));

    // 50 MHz system clock
    initial begin
        forever #10 i_clock = ~i_clock;
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // One-cycle write; the edge after it passes before the next strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    // Control write with done cleared and enable set
    task automatic arm(input logic [2:0] s, input logic tm, input logic go);
        wr(`SACS_ADDR_CONTROL, {1'b1, tm, 1'b0, go, s, 1'b0});
    endtask

    task automatic pulse_primary();
        @(posedge i_clock);
        primary_write <= 1'b1;
        @(posedge i_clock);
        primary_write <= 1'b0;
    endtask

    // Follows one conversion to its end, counting ticks per phase
    task automatic run_conv(input int trk_exp);
        int cv, tk, irq, last, t;
        logic [7:0] d;
        cv = 0;
        tk = 0;
        irq = 0;
        last = -1;
        for (t = 0; t < 3000 && o_done !== 1'b1; t++) begin
            @(posedge i_clock);
            #1;
            irq += (o_irq === 1'b1);
            if (o_tick === 1'b1 && o_track === 1'b1) tk++;
            if (o_tick === 1'b1 && o_convert === 1'b1) begin
                if (last >= 0) chk("tick spacing", 8'(DIV + 1), 8'(t - last));
                last = t;
                cv++;
            end
        end
        chk("convert ticks", 8'h08, 8'(cv));
        chk("track ticks", 8'(trk_exp), 8'(tk));
        chk("irq pulses", 8'h01, 8'(irq));
        chk("converting", 8'h00, {7'h0, o_convert});
        rd(`SACS_ADDR_DATA, d);
        chk("data word", i_sar_result, d);
        rd(`SACS_ADDR_CONTROL, d);
        chk("done flag", 8'h01, {7'h0, d[`SACS_CTL_DONE]});
    endtask

    task automatic t_reset();
        logic [7:0] d;
        rd(`SACS_ADDR_CONFIG, d);
        chk("config reset", `SACS_CFG_RESET, d);
        chk("gain reset", 8'h00, {6'h0, o_gain});
        rd(`SACS_ADDR_CONTROL, d);
        chk("control reset", `SACS_CTL_RESET, d);
        rd(4'hF, d);
        chk("unmapped", 8'h00, d);
        wr(`SACS_ADDR_CHANNEL, 8'hFF);
        rd(`SACS_ADDR_CHANNEL, d);
        chk("channel", 8'h07, {5'h0, o_chan} & d);
    endtask

    // Every gain code reaches the amplifier and reads back
    task automatic t_gain();
        logic [7:0] d;
        for (int g = 3; g >= 0; g--) begin
            wr(`SACS_ADDR_CONFIG, {DIV, 1'b0, 2'(g)});
            rd(`SACS_ADDR_CONFIG, d);
            chk("gain out", 8'(g), {6'h0, o_gain});
            chk("config", {DIV, 3'(g)}, d);
        end
    endtask

    task automatic t_soft();
        logic [7:0] d;
        i_sar_result <= 8'hA5;
        arm(SACS_SRC_SOFT, 1'b0, 1'b0);
        #1 chk("enable out", 8'h01, {7'h0, o_enable});
        arm(SACS_SRC_SOFT, 1'b0, 1'b1);
        rd(`SACS_ADDR_CONTROL, d);
        chk("busy", 8'h01, {7'h0, d[`SACS_CTL_BUSY]});
        run_conv(0);
    endtask

    // Each hardware source, then a code with no source behind it
    task automatic t_sources();
        sacs_src_e s;
        for (int k = 0; k < 4; k++) begin
            s = sacs_src_e'(k + 1);
            i_sar_result <= 8'(8'h30 + k);
            wr(`SACS_ADDR_CONTROL, 8'h00);
            arm(s, 1'b0, 1'b0);
            if (s == SACS_SRC_EXTERNAL) begin
                ext_req <= 1'b0;
                repeat (3) @(posedge i_clock);
                ext_req <= 1'b1;
            end
            if (s == SACS_SRC_SHARED) pulse_primary();
            run_conv(0);
        end
        // Shared start through its register alias
        i_sar_result <= 8'h3C;
        arm(SACS_SRC_SHARED, 1'b0, 1'b0);
        wr(`SACS_ADDR_SHARED, 8'h10);
        run_conv(0);
        wr(`SACS_ADDR_CONTROL, 8'h00);
        arm(3'h5, 1'b0, 1'b0);
        pulse_primary();
        repeat (150) @(posedge i_clock);
        #1 chk("no source", 8'h00, {6'h0, o_convert, o_done});
    endtask

    // Disabled block ignores a busy write and the shared trigger
    task automatic t_disabled();
        logic [7:0] d;
        wr(`SACS_ADDR_CONTROL, 8'h10);
        wr(`SACS_ADDR_CONTROL, 8'h10);
        wr(`SACS_ADDR_CONTROL, 8'h18);
        pulse_primary();
        repeat (150) @(posedge i_clock);
        rd(`SACS_ADDR_CONTROL, d);
        chk("disabled busy", 8'h00, {5'h0, o_enable, o_convert, d[`SACS_CTL_BUSY]});
    endtask

    task automatic t_lowpower();
        i_sar_result <= 8'h5A;
        arm(SACS_SRC_SOFT, 1'b1, 1'b0);
        arm(SACS_SRC_SOFT, 1'b1, 1'b1);
        run_conv(3);
        arm(SACS_SRC_EXTERNAL, 1'b1, 1'b0);
        ext_req <= 1'b0;
        repeat (4) @(posedge i_clock);
        #1 chk("track low pin", 8'h01, {7'h0, o_track});
        @(posedge i_clock);
        ext_req <= 1'b1;
        run_conv(0);
    endtask

    // Idle normal mode tracks unless the chip stands by
    task automatic t_standby();
        arm(SACS_SRC_SOFT, 1'b0, 1'b0);
        repeat (3) @(posedge i_clock);
        #1 chk("idle track", 8'h01, {7'h0, o_track});
        @(posedge i_clock);
        standby <= 1'b1;
        repeat (3) @(posedge i_clock);
        #1 chk("standby track", 8'h00, {7'h0, o_track});
        @(posedge i_clock);
        standby <= 1'b0;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst_b <= 1'b1;
        t_reset();
        t_gain();
        t_soft();
        t_sources();
        t_disabled();
        t_lowpower();
        t_standby();
        print_verdict();
    end

    // Watchdog at 20000 cycles, well beyond the thousand or so cycles the run needs
    initial begin
        #400000;
        n_errors++;
        print_verdict();
    end
endmodule // sacs_sequencer_tb_top
